//--- rtl/ictl_consts.svh
`ifndef ICTL_CONSTS_SVH
`define ICTL_CONSTS_SVH
// register byte addresses on the register bus
`define ICTL_A_SMC 8'h00
`define ICTL_A_EDGE 8'h04
`define ICTL_A_C0 8'h08
`define ICTL_A_C1 8'h0C
`define ICTL_A_C2 8'h10
`define ICTL_A_C3 8'h14
// supply_monitor_ctrl field positions
`define ICTL_SMC_LOW_BIT 5
`define ICTL_SMC_EN_BIT 4
`define ICTL_SMC_REF_BIT 3
// reset value of every control byte
`define ICTL_RST_BYTE 8'h00
// bus answers
`define ICTL_RESP_OKAY 2'h0
`define ICTL_RESP_SLVERR 2'h2
// timing: clock period and delay from supply-low flag to request
`define ICTL_CLK_NS 10
`define ICTL_MON_DELAY_NS 100000
`define ICTL_MON_DELAY_CYC ((`ICTL_MON_DELAY_NS + `ICTL_CLK_NS - 1) / `ICTL_CLK_NS)
`endif

//--- rtl/ictl_pkg.sv
`default_nettype none
package ictl_pkg;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic aw_held;
		logic w_held;
		logic wstrb0;
		logic [7:0] awaddr;
		logic [7:0] wdata;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [2:0] thr;
		logic reference_buffer_enable;
		logic supply_monitor_enable;
		logic det_on;
		logic low_flag;
		logic [15:0] dly;
		logic ref_on;
		logic [11:0] thr_mv;
		logic [3:0] edge_sel;
		logic [1:0] sync1;
		logic [1:0] sync2;
		logic [1:0] last;
		logic [13:0] flag;
		logic [13:0] en;
		logic global_irq_enable;
		logic irq;
		logic [3:0] vec;
		logic wake;
	} ictl_state_t;
endpackage
`default_nettype wire

//--- rtl/ictl_top.sv
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`include "ictl_consts.svh"
`default_nettype none
module ictl_top
	import ictl_pkg::*;
#(
	parameter logic [15:0] MON_DELAY_CYC = 16'(`ICTL_MON_DELAY_CYC)
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_pin_zero,
	input wire logic ext_pin_one,
	input wire logic [10:0] periph_evt,
	input wire logic supply_below_level,
	input wire logic low_supply_reset_en,
	input wire logic pin_zero_absent,
	input wire logic deep_sleep,
	input wire logic idle_mode,
	input wire logic stack_full,
	input wire logic irq_ack,
	output logic irq_req,
	output logic [3:0] irq_vector,
	output logic wake_req,
	output logic detector_on,
	output logic reference_on,
	output logic supply_low_flag,
	output logic [11:0] threshold_mv
);
	ictl_state_t s;
	ictl_state_t n;
	logic [13:0] set_ev;
	logic [13:0] pend;
	logic [13:0] avail;
	logic [1:0] pin_hit;
	logic mon_hit;
	logic do_write;
	logic [8:0] rd;
	logic [8:0] wmap;

	// trip level in millivolts for each threshold code
	function automatic logic [11:0] level_mv(input logic [2:0] c);
		case (c)
			3'h0: level_mv = 12'h7D0;
			3'h1: level_mv = 12'h898;
			3'h2: level_mv = 12'h960;
			3'h3: level_mv = 12'hA8C;
			3'h4: level_mv = 12'hBB8;
			3'h5: level_mv = 12'hCE4;
			3'h6: level_mv = 12'hE10;
			default: level_mv = 12'hFA0;
		endcase
	endfunction

	// edge qualification shared by both pins
	function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prev);
		edge_hit = (sel[0] & cur & ~prev) | (sel[1] & ~cur & prev);
	endfunction

	// lowest index wins so earlier sources outrank later ones
	function automatic logic [3:0] prio(input logic [13:0] p);
		prio = 4'h0;
		for (int i = 13; i >= 0; i--)
		begin
			if (p[i])
			begin
				prio = 4'(i);
			end
		end
	endfunction

	// read mux; bit 8 marks a mapped address, spare bits are constant zero
	function automatic logic [8:0] rd_reg(input logic [7:0] a, input ictl_state_t q);
		case (a)
			`ICTL_A_SMC: rd_reg = {1'b1, 2'b00, q.low_flag, q.supply_monitor_enable, q.reference_buffer_enable, q.thr};
			`ICTL_A_EDGE: rd_reg = {1'b1, 4'h0, q.edge_sel};
			`ICTL_A_C0: rd_reg = {1'b1, 1'b0, q.flag[1], q.flag[0], q.flag[2],
				q.en[1], q.en[0], q.en[2], q.global_irq_enable};
			`ICTL_A_C1: rd_reg = {1'b1, q.flag[9], q.flag[4], q.flag[8], q.flag[7],
				q.en[9], q.en[4], q.en[8], q.en[7]};
			`ICTL_A_C2: rd_reg = {1'b1, q.flag[11], q.flag[10], q.flag[13], q.flag[12],
				q.en[11], q.en[10], q.en[13], q.en[12]};
			`ICTL_A_C3: rd_reg = {1'b1, 1'b0, q.flag[3], q.flag[6], q.flag[5],
				1'b0, q.en[3], q.en[6], q.en[5]};
			default: rd_reg = 9'h000;
		endcase
	endfunction

	// whole block next state
	always_comb
	begin
		n = s;
		// pins: sync1 feeds only sync2, edges come from sync2 against last
		n.sync1 = {ext_pin_one, ext_pin_zero};
		n.sync2 = s.sync1;
		n.last = s.sync2;
		pin_hit[0] = edge_hit(s.edge_sel[1:0], s.sync2[0], s.last[0]) & ~pin_zero_absent;
		pin_hit[1] = edge_hit(s.edge_sel[3:2], s.sync2[1], s.last[1]);
		// monitor: off when disabled or in deepest sleep
		n.det_on = s.supply_monitor_enable & ~deep_sleep;
		n.low_flag = s.det_on & supply_below_level;
		mon_hit = s.low_flag && (s.dly == MON_DELAY_CYC - 16'h0001);
		if (!s.low_flag)
		begin
			n.dly = 16'h0000;
		end
		else if (s.dly != MON_DELAY_CYC)
		begin
			n.dly = s.dly + 16'h0001;
		end
		// request sources in priority order
		set_ev = {periph_evt[10:6], mon_hit, periph_evt[5:0], pin_hit};
		// service: core took the vector, so drop its flag and the global enable
		if (irq_ack && s.irq)
		begin
			n.global_irq_enable = 1'b0;
			n.flag[s.vec] = 1'b0;
		end
		// write channel capture; either order is accepted
		if (s_axi_awvalid && s.awready)
		begin
			n.aw_held = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready)
		begin
			n.w_held = 1'b1;
			n.wdata = s_axi_wdata[7:0];
			n.wstrb0 = s_axi_wstrb[0];
		end
		// decode of the held write address, only its mapped bit is used
		wmap = rd_reg(s.awaddr, s);
		do_write = s.aw_held && s.w_held && !s.bvalid;
		if (do_write)
		begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = wmap[8] ? `ICTL_RESP_OKAY : `ICTL_RESP_SLVERR;
			if (s.wstrb0)
			begin
				case (s.awaddr)
					`ICTL_A_SMC:
					begin
						n.supply_monitor_enable = s.wdata[`ICTL_SMC_EN_BIT];
						n.reference_buffer_enable = s.wdata[`ICTL_SMC_REF_BIT];
						n.thr = s.wdata[2:0];
					end
					`ICTL_A_EDGE: n.edge_sel = s.wdata[3:0];
					`ICTL_A_C0: {n.flag[1], n.flag[0], n.flag[2], n.en[1], n.en[0], n.en[2],
						n.global_irq_enable} = s.wdata[6:0];
					`ICTL_A_C1: {n.flag[9], n.flag[4], n.flag[8], n.flag[7], n.en[9], n.en[4],
						n.en[8], n.en[7]} = s.wdata;
					`ICTL_A_C2: {n.flag[11], n.flag[10], n.flag[13], n.flag[12], n.en[11],
						n.en[10], n.en[13], n.en[12]} = s.wdata;
					`ICTL_A_C3: {n.flag[3], n.flag[6], n.flag[5], n.en[3], n.en[6],
						n.en[5]} = {s.wdata[6:4], s.wdata[2:0]};
					default: n.thr = s.thr;
				endcase
			end
		end
		if (s.bvalid && s_axi_bready)
		begin
			n.bvalid = 1'b0;
		end
		n.awready = ~n.aw_held;
		n.wready = ~n.w_held;
		// read channel: one read in flight, answer one cycle after address
		rd = rd_reg(s_axi_araddr, s);
		if (s_axi_arvalid && s.arready)
		begin
			n.rvalid = 1'b1;
			n.rdata = {24'h00_0000, rd[7:0]};
			n.rresp = rd[8] ? `ICTL_RESP_OKAY : `ICTL_RESP_SLVERR;
		end
		else if (s.rvalid && s_axi_rready)
		begin
			n.rvalid = 1'b0;
		end
		n.arready = ~n.rvalid;
		// hardware set wins over software clear or service clear
		n.flag = n.flag | set_ev;
		// wake only on a flag newly set by an event, preset flags stay quiet
		n.wake = (deep_sleep | idle_mode) & |(set_ev & ~s.flag);
		// pending = flag and own enable; pin zero counts for nothing when absent
		avail = {13'h1FFF, ~pin_zero_absent};
		pend = n.flag & n.en & avail;
		n.irq = n.global_irq_enable & (|pend) & ~stack_full;
		n.vec = prio(pend);
		n.ref_on = n.reference_buffer_enable | n.supply_monitor_enable | low_supply_reset_en;
		n.thr_mv = level_mv(n.thr);
	end

	// single register for all state, synchronous active-low reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s <= '0;
		end
		else
		begin
			s <= n;
		end
	end

	// outputs are taken directly from the state register
	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign irq_req = s.irq;
	assign irq_vector = s.vec;
	assign wake_req = s.wake;
	assign detector_on = s.det_on;
	assign reference_on = s.ref_on;
	assign supply_low_flag = s.low_flag;
	assign threshold_mv = s.thr_mv;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence pin1_rise_armed;
		s.sync2[1] && !s.last[1] && s.edge_sel[2];
	endsequence
	sequence svc_taken;
		irq_ack && s.irq;
	endsequence
	sequence smc_read_taken;
		s_axi_arvalid && s.arready && (s_axi_araddr == `ICTL_A_SMC);
	endsequence

	chk_thr_top: assert property (s.thr == 3'h7 |-> s.thr_mv == 12'hFA0)
		else $error("top threshold code not 4.0 V");
	chk_low_needs_det: assert property (!s.det_on |=> !s.low_flag)
		else $error("low flag while detector off");
	chk_sleep_off: assert property (deep_sleep |=> !s.det_on ##1 !s.low_flag)
		else $error("monitor active in deep sleep");
	chk_ref_follow: assert property ((s.supply_monitor_enable || s.reference_buffer_enable) |-> s.ref_on)
		else $error("reference off while requested");
	chk_mon_delay: assert property (mon_hit |-> s.low_flag && $past(s.low_flag))
		else $error("monitor request without held low flag");
	chk_irq_cause: assert property (s.irq |-> s.global_irq_enable && s.flag[s.vec] && s.en[s.vec])
		else $error("interrupt without enabled pending flag");
	chk_svc_clears: assert property (svc_taken |=> !s.global_irq_enable)
		else $error("global enable kept after service");
	chk_stack_block: assert property (stack_full |=> !s.irq)
		else $error("interrupt raised with stack full");
	chk_pin1_edge: assert property (pin1_rise_armed |=> s.flag[1])
		else $error("rising edge on pin one lost");
	chk_pin0_gone: assert property (pin_zero_absent |=> !(s.irq && s.vec == 4'h0))
		else $error("absent pin zero raised interrupt");

	// spare bit read-back check on the bus, then gating and power checks
	chk_spare_zero: assert property (smc_read_taken |=> s.rdata[7:6] == 2'b00)
		else $error("spare monitor bits read nonzero");
	chk_gie_gates: assert property (!s.global_irq_enable |-> !s.irq)
		else $error("interrupt with global enable off");
	chk_wake_state: assert property (s.wake |-> $past(deep_sleep || idle_mode))
		else $error("wake request outside sleep or idle");
	chk_det_follow: assert property (s.supply_monitor_enable && !deep_sleep |=> s.det_on)
		else $error("detector off while enabled");
	chk_ref_lsr: assert property (low_supply_reset_en |=> s.ref_on)
		else $error("reference off with low supply reset on");
endmodule
`default_nettype wire

//--- dv/testbench.sv
`include "ictl_consts.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, rd;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic pin0 = 1'b0, pin1 = 1'b0, below = 1'b0, lvr_en = 1'b0, p0_absent = 1'b0;
	logic dsleep = 1'b0, idle = 1'b0, sfull = 1'b0, ack = 1'b0;
	logic [10:0] evt = 11'h000;
	logic [1:0] rs;
	wire logic awready, wready, bvalid, arready, rvalid, irq_req, wake_req, det_on, ref_on, low_flag;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [3:0] vec;
	wire logic [11:0] thr_mv;
	int mismatches = 0, n_tests = 0, cyc = 0;
	// short monitor delay keeps the run brief; expectations use the same 8
	ictl_top #(.MON_DELAY_CYC(16'h0008)) i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ext_pin_zero(pin0), .ext_pin_one(pin1), .periph_evt(evt), .supply_below_level(below),
		.low_supply_reset_en(lvr_en), .pin_zero_absent(p0_absent), .deep_sleep(dsleep),
		.idle_mode(idle), .stack_full(sfull), .irq_ack(ack), .irq_req(irq_req),
		.irq_vector(vec), .wake_req(wake_req), .detector_on(det_on), .reference_on(ref_on),
		.supply_low_flag(low_flag), .threshold_mv(thr_mv));
	always #5 aclk = ~aclk;
	// watchdog: the whole sequence needs well under this many cycles
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			mismatches++;
			give_verdict();
		end
	end
	task give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	// each channel is released at the edge that takes it; no fixed latency assumed
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge aclk);
		{awaddr, wdata} <= {a, 24'h00_0000, d};
		{awvalid, wvalid, bready} <= 3'h7;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) {bready, rs} <= {1'b0, bresp};
		end
		while (awvalid || wvalid || bready);
	endtask
	task rdr(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) {rready, rs, rd} <= {1'b0, rresp, rdata[7:0]};
		end
		while (arvalid || rready);
	endtask
	task rchk(input logic [7:0] a, input logic [7:0] e);
		rdr(a);
		chk($sformatf("reg %h", a), e, rd);
		chk("rresp", `ICTL_RESP_OKAY, rs);
	endtask
	task pulse(input int i);
		@(posedge aclk);
		evt <= 11'h001 << i;
		@(posedge aclk);
		evt <= 11'h000;
	endtask
	// reset values, unmapped place, and unimplemented bits reading zero
	task automatic t_regs();
		logic [7:0] msk [6] = '{8'h1f, 8'h0f, 8'h7f, 8'hff, 8'hff, 8'h77};
		for (int i = 0; i < 6; i++) rchk(8'(4 * i), 8'h00);
		rdr(8'h18);
		chk("unmapped rresp", `ICTL_RESP_SLVERR, rs);
		wr(8'h18, 8'hff);
		chk("unmapped bresp", `ICTL_RESP_SLVERR, rs);
		for (int i = 0; i < 6; i++)
		begin
			wr(8'(4 * i), 8'hff);
			chk("bresp", `ICTL_RESP_OKAY, rs);
			rchk(8'(4 * i), msk[i]);
			wr(8'(4 * i), 8'h00);
		end
	endtask
	task automatic t_thr();
		logic [11:0] mv [8] = '{12'h7d0, 12'h898, 12'h960, 12'ha8c,
			12'hbb8, 12'hce4, 12'he10, 12'hfa0};
		for (int i = 0; i < 8; i++)
		begin
			wr(`ICTL_A_SMC, 8'(i));
			repeat (2) @(posedge aclk);
			chk("threshold_mv", mv[i], thr_mv);
		end
	endtask
	// reference sources, detector, flag, delayed request, deep sleep
	task t_mon();
		wr(`ICTL_A_SMC, 8'h00);
		lvr_en <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("reference_on", 1, ref_on);
		lvr_en <= 1'b0;
		wr(`ICTL_A_SMC, 8'h08);
		repeat (2) @(posedge aclk);
		chk("reference_on", 1, ref_on);
		wr(`ICTL_A_SMC, 8'h10);
		repeat (2) @(posedge aclk);
		below <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("detector_on", 1, det_on);
		chk("supply_low_flag", 1, low_flag);
		rchk(`ICTL_A_C1, 8'h00);
		rchk(`ICTL_A_SMC, 8'h30);
		repeat (6) @(posedge aclk);
		rchk(`ICTL_A_C1, 8'h20);
		dsleep <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("sleep detector_on", 0, det_on);
		chk("sleep supply_low_flag", 0, low_flag);
		dsleep <= 1'b0;
		wr(`ICTL_A_SMC, 8'h00);
		repeat (3) @(posedge aclk);
		chk("off supply_low_flag", 0, low_flag);
		below <= 1'b0;
		wr(`ICTL_A_C1, 8'h00);
	endtask
	// every edge mode on pin one, then pin zero with the variant strap
	task t_pins();
		for (int m = 0; m < 4; m++)
		begin
			wr(`ICTL_A_EDGE, 8'(m << 2));
			wr(`ICTL_A_C0, 8'h00);
			pin1 <= 1'b1;
			repeat (5) @(posedge aclk);
			rchk(`ICTL_A_C0, m[0] ? 8'h40 : 8'h00);
			wr(`ICTL_A_C0, 8'h00);
			pin1 <= 1'b0;
			repeat (5) @(posedge aclk);
			rchk(`ICTL_A_C0, m[1] ? 8'h40 : 8'h00);
		end
		wr(`ICTL_A_EDGE, 8'h03);
		wr(`ICTL_A_C0, 8'h00);
		p0_absent <= 1'b1;
		pin0 <= 1'b1;
		repeat (5) @(posedge aclk);
		rchk(`ICTL_A_C0, 8'h00);
		p0_absent <= 1'b0;
		pin0 <= 1'b0;
		repeat (5) @(posedge aclk);
		rchk(`ICTL_A_C0, 8'h20);
		wr(`ICTL_A_C0, 8'h00);
	endtask
	// gating by global enable and stack, priority, service clearing
	task t_irq();
		wr(`ICTL_A_C1, 8'h04);
		wr(`ICTL_A_C0, 8'h02);
		pulse(2);
		repeat (2) @(posedge aclk);
		chk("irq_req off", 0, irq_req);
		wr(`ICTL_A_C0, 8'h03);
		repeat (2) @(posedge aclk);
		chk("irq_req", 1, irq_req);
		chk("irq_vector", 4, vec);
		sfull <= 1'b1;
		repeat (2) @(posedge aclk);
		chk("irq_req full", 0, irq_req);
		sfull <= 1'b0;
		pulse(0);
		repeat (2) @(posedge aclk);
		chk("irq_vector", 2, vec);
		ack <= 1'b1;
		@(posedge aclk);
		ack <= 1'b0;
		repeat (2) @(posedge aclk);
		chk("irq_req served", 0, irq_req);
		rchk(`ICTL_A_C0, 8'h02);
		rchk(`ICTL_A_C1, 8'h44);
		wr(`ICTL_A_C1, 8'h00);
	endtask
	task t_wake();
		idle <= 1'b1;
		// wake stands one cycle, from the edge that takes the pulse
		pulse(3);
		#1 chk("wake_req", 1, wake_req);
		pulse(3);
		#1 chk("wake_req preset", 0, wake_req);
		idle <= 1'b0;
	endtask
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_regs();
		t_thr();
		t_mon();
		t_pins();
		t_irq();
		t_wake();
		give_verdict();
	end
endmodule
`default_nettype wire
